// ---- src/mcsp_map.svh ----
// register offsets, field positions, reset values and counts of the clock block
`ifndef MCSP_MAP_SVH
`define MCSP_MAP_SVH
`define MCSP_OFS_SEL    5'h00
`define MCSP_OFS_PRE    5'h01
`define MCSP_OFS_LOCK   5'h02
`define MCSP_OFS_STAT   5'h03
`define MCSP_OFS_FAST   5'h10
`define MCSP_OFS_CALA   5'h11
`define MCSP_OFS_CALB   5'h12
`define MCSP_OFS_SLOW   5'h18
`define MCSP_OFS_XTAL   5'h1c
`define MCSP_OFS_GUARD  5'h1f
`define MCSP_SEL_RST    2'h0
`define MCSP_PRE_RST    8'h11
`define MCSP_RSB_BIT    1
`define MCSP_XEN_BIT    0
`define MCSP_XSEL_BIT   2
`define MCSP_CSUT_LSB   4
`define MCSP_PEN_BIT    0
`define MCSP_DIVISION_FIELD_LSB   1
`define MCSP_CALB_LOCK  7
`define MCSP_GUARD_KEY  8'h5a
`define MCSP_GUARD_CYC  3'h4
`define MCSP_OSC_EXTRA  8'h04
`define MCSP_EXT_EDGES  8'h02
`define MCSP_CSUT0      8'h10
`define MCSP_CSUT1      8'h20
`define MCSP_CSUT2      8'h40
`define MCSP_CSUT3      8'h80
`endif

// ---- src/mcsp_pkg.sv ----
// types shared by the main clock select and prescale block
package mcsp_pkg;
    typedef enum logic [1:0] {
        MCSP_SRC_FAST = 2'h0,
        MCSP_SRC_SLOW = 2'h1,
        MCSP_SRC_XTAL = 2'h2,
        MCSP_SRC_EXT  = 2'h3
    } mcsp_src_e;
    typedef enum logic [1:0] {
        MCSP_ACTIVE  = 2'h0,
        MCSP_IDLE    = 2'h1,
        MCSP_STANDBY = 2'h2,
        MCSP_PDOWN   = 2'h3
    } mcsp_sleep_e;
    typedef enum logic [1:0] {
        MCSP_SW_IDLE = 2'h0,
        MCSP_SW_WAIT = 2'h1,
        MCSP_SW_DONE = 2'h3
    } mcsp_sw_e;
endpackage

// ---- src/mcsp_prescaler.sv ----
// peripheral clock enable generator dividing the main clock
`timescale 1ns/1ps
`default_nettype none
module mcsp_prescaler (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       prescale_enable,
    input  wire logic [3:0] division_field,
    output var  logic       per_clock_en
);
    logic [5:0] count_reg;
    logic [5:0] last_cnt;

    // division factor minus one; reserved codes fall back to divide by 2
    always_comb begin
        last_cnt = 6'h00;
        if (prescale_enable) begin
            unique case (division_field)
                4'h0:    last_cnt = 6'h01;
                4'h1:    last_cnt = 6'h03;
                4'h2:    last_cnt = 6'h07;
                4'h3:    last_cnt = 6'h0f;
                4'h4:    last_cnt = 6'h1f;
                4'h5:    last_cnt = 6'h3f;
                4'h8:    last_cnt = 6'h05;
                4'h9:    last_cnt = 6'h09;
                4'ha:    last_cnt = 6'h0b;
                4'hb:    last_cnt = 6'h17;
                4'hc:    last_cnt = 6'h2f;
                default: last_cnt = 6'h01;
            endcase
        end
    end

    // a shrunk factor restarts the count at once instead of wrapping
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count_reg    <= 6'h00;
            per_clock_en <= 1'b0;
        end else if (count_reg >= last_cnt) begin
            count_reg    <= 6'h00;
            per_clock_en <= 1'b1;
        end else begin
            count_reg    <= count_reg + 6'h01;
            per_clock_en <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- src/mcsp_top.sv ----
// main clock source selection, oscillator requests, calibration and prescaler
//
// Contract
// [RQ1] sources nobody requests or uses are switched off
// [RQ2] run-in-standby keeps an oscillator running except in power down
// [RQ3] run-in-standby sources serve requests with no start-up wait
// [RQ4] main clock always runs in active and idle
// [RQ5] standby runs main clock only on request or run-in-standby
// [RQ6] power down stops main clock after nonvolatile operations finish
// [RQ7] switch to external source completes only after enough edges
// [RQ8] while external switch waits, further selection changes are refused
// [RQ9] pending flag reads set during a source switch
// [RQ10] status flags report external clock and crystal stability
// [RQ11] peripheral clock is main clock divided by 1 to 64
// [RQ12] select and prescaler registers change only via guarded write
// [RQ13] reset selects fast internal oscillator and divide by six
// [RQ14] fast oscillator runs at 16 or 20 MHz per fuse
// [RQ15] internal sources enable automatically on peripheral request
// [RQ16] crystal serves only after software sets its enable bit
// [RQ17] calibration fields load from fuses at reset
// [RQ18] lock fuse makes calibration writes ineffective
// [RQ19] calibration locked when fast osc is main and lock enabled
// [RQ20] calibration fields change only via guarded write
// [RQ21] fast oscillator delivers after start-up plus 4 cycles
// [RQ22] software lowers main clock before calibration changes
// [RQ23] select field codes choose the four sources
// [RQ24] division field codes select the documented factors
// [RQ25] prescaler disabled means no division
`timescale 1ns/1ps
`default_nettype none
`include "mcsp_map.svh"
module mcsp_top (
    input  wire logic               clock,
    input  wire logic               rst_n,
    input  wire logic [4:0]         reg_addr,
    input  wire logic [7:0]         reg_wdata,
    input  wire logic               reg_write,
    input  wire logic               reg_read,
    output var  logic [7:0]         reg_rdata,
    input  wire mcsp_pkg::mcsp_sleep_e sleep_mode,
    input  wire logic               nvm_busy,
    input  wire logic [3:0]         periph_req,
    input  wire logic [3:0]         osc_started,
    input  wire logic [3:0]         osc_edge,
    input  wire logic               freq_select_fuse,
    input  wire logic [5:0]         center_cal_fuse,
    input  wire logic [3:0]         temp_cal_fuse,
    input  wire logic               osc_cal_lock_fuse,
    output var  logic [3:0]         src_enable,
    output var  mcsp_pkg::mcsp_src_e main_src,
    output var  logic               main_clock_run,
    output var  logic               per_clock_en,
    output var  logic               fast_osc_20m,
    output var  logic [5:0]         center_freq_cal,
    output var  logic [3:0]         temp_slope_cal,
    output var  logic               crystal_ext_input
);
    import mcsp_pkg::*;

    // ----
    // register state
    // ----
    logic [1:0] sel_reg;
    logic       pen_reg;
    logic [3:0] division_field_reg;
    logic       lock_en_reg;
    logic [2:0] rsb_reg;
    logic       xtal_en_reg;
    logic [1:0] csut_reg;
    logic [2:0] guard_reg;
    logic       loaded_reg;
    mcsp_src_e  target_reg;
    mcsp_sw_e   sw_reg;
    logic [3:0] stable;
    logic [3:0] src_want;
    logic [3:0] need_main;
    logic       run_next;
    logic       guard_ok;
    logic       cal_locked;
    logic       wr_sel;
    logic [7:0] rd_value;

    assign guard_ok = (guard_reg != 3'h0);
    assign wr_sel   = reg_write && guard_ok && (reg_addr == `MCSP_OFS_SEL);

    // ----
    // write guard
    // ----
    // [RQ12] key opens window
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            guard_reg <= 3'h0;
        end else if (reg_write && reg_addr == `MCSP_OFS_GUARD
                     && reg_wdata == `MCSP_GUARD_KEY) begin
            guard_reg <= `MCSP_GUARD_CYC;
        end else if (guard_ok) begin
            guard_reg <= guard_reg - 3'h1;
        end
    end

    // ----
    // control registers
    // ----
    // [RQ13] reset defaults
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pen_reg  <= 1'(`MCSP_PRE_RST >> `MCSP_PEN_BIT);
            division_field_reg <= 4'((`MCSP_PRE_RST) >> `MCSP_DIVISION_FIELD_LSB);
        end else if (reg_write && guard_ok && reg_addr == `MCSP_OFS_PRE) begin
            // [RQ12] guarded prescaler
            pen_reg  <= reg_wdata[`MCSP_PEN_BIT];
            division_field_reg <= reg_wdata[`MCSP_DIVISION_FIELD_LSB +: 4];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            lock_en_reg <= 1'b0;
            rsb_reg     <= 3'h0;
            xtal_en_reg <= 1'b0;
            csut_reg    <= 2'h0;
            crystal_ext_input <= 1'b0;
        end else if (reg_write && guard_ok) begin
            unique case (reg_addr)
                `MCSP_OFS_LOCK: lock_en_reg <= reg_wdata[0];
                `MCSP_OFS_FAST: rsb_reg[0] <= reg_wdata[`MCSP_RSB_BIT];
                `MCSP_OFS_SLOW: rsb_reg[1] <= reg_wdata[`MCSP_RSB_BIT];
                `MCSP_OFS_XTAL: begin
                    // [RQ16] crystal enable bit
                    xtal_en_reg       <= reg_wdata[`MCSP_XEN_BIT];
                    rsb_reg[2]        <= reg_wdata[`MCSP_RSB_BIT];
                    crystal_ext_input <= reg_wdata[`MCSP_XSEL_BIT];
                    csut_reg          <= reg_wdata[`MCSP_CSUT_LSB +: 2];
                end
                default: ;
            endcase
        end
    end

    // ----
    // calibration and fuse capture
    // ----
    assign cal_locked = osc_cal_lock_fuse
                        || (main_src == MCSP_SRC_FAST && lock_en_reg);

    // fuses are caught on the first edge after reset release
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            loaded_reg      <= 1'b0;
            center_freq_cal <= 6'h00;
            temp_slope_cal  <= 4'h0;
            fast_osc_20m    <= 1'b0;
        end else if (!loaded_reg) begin
            // [RQ17] fuse load
            loaded_reg      <= 1'b1;
            center_freq_cal <= center_cal_fuse;
            temp_slope_cal  <= temp_cal_fuse;
            // [RQ14] frequency fuse
            fast_osc_20m    <= freq_select_fuse;
        end else if (reg_write && guard_ok && !cal_locked) begin
            // [RQ18] [RQ19] [RQ20] locked or unguarded writes dropped
            if (reg_addr == `MCSP_OFS_CALA) begin
                center_freq_cal <= reg_wdata[5:0];
            end
            if (reg_addr == `MCSP_OFS_CALB) begin
                temp_slope_cal <= reg_wdata[3:0];
            end
        end
    end

    // ----
    // main clock run control
    // ----
    always_comb begin
        run_next = 1'b1;
        unique case (sleep_mode)
            // [RQ4] always on
            MCSP_ACTIVE,
            MCSP_IDLE:    run_next = 1'b1;
            // [RQ5] standby on demand
            MCSP_STANDBY: run_next = periph_req[main_src]
                                     || (main_src != MCSP_SRC_EXT
                                         && rsb_reg[main_src]);
            // [RQ6] wait for nvm
            MCSP_PDOWN:   run_next = nvm_busy;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            main_clock_run <= 1'b1;
        end else begin
            main_clock_run <= run_next;
        end
    end

    // ----
    // per-source request, sync and stability
    // ----
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_src
            logic       edge_s1;
            logic       edge_s2;
            logic       edge_s3;
            logic       start_s1;
            logic       start_s2;
            logic [7:0] cnt_reg;
            logic [7:0] need;
            logic       stable_reg;
            logic       keep;

            assign keep = (gi < 3) && rsb_reg[gi % 3]
                          && sleep_mode != MCSP_PDOWN;
            assign need_main[gi] = (main_src == gi && run_next)
                || (sw_reg == MCSP_SW_WAIT && target_reg == gi);
            // [RQ1] [RQ2] [RQ15] demand-driven enable
            assign src_want[gi] = (periph_req[gi] || need_main[gi] || keep)
                && (gi != MCSP_SRC_XTAL || xtal_en_reg);
            assign stable[gi] = stable_reg;

            always_comb begin
                need = `MCSP_OSC_EXTRA;
                if (gi == MCSP_SRC_EXT
                    || (gi == MCSP_SRC_XTAL && crystal_ext_input)) begin
                    need = `MCSP_EXT_EDGES;
                end else if (gi == MCSP_SRC_XTAL) begin
                    unique case (csut_reg)
                        2'h0: need = `MCSP_CSUT0;
                        2'h1: need = `MCSP_CSUT1;
                        2'h2: need = `MCSP_CSUT2;
                        2'h3: need = `MCSP_CSUT3;
                    endcase
                end
            end

            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    edge_s1  <= 1'b0;
                    edge_s2  <= 1'b0;
                    edge_s3  <= 1'b0;
                    start_s1 <= 1'b0;
                    start_s2 <= 1'b0;
                end else begin
                    edge_s1  <= osc_edge[gi];
                    edge_s2  <= edge_s1;
                    edge_s3  <= edge_s2;
                    start_s1 <= osc_started[gi];
                    start_s2 <= start_s1;
                end
            end

            // [RQ21] start-up then counted cycles
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    cnt_reg    <= 8'h00;
                    stable_reg <= 1'b0;
                end else if (!src_enable[gi] || !start_s2) begin
                    cnt_reg    <= 8'h00;
                    stable_reg <= 1'b0;
                end else if (!stable_reg && edge_s2 && !edge_s3) begin
                    cnt_reg    <= cnt_reg + 8'h01;
                    stable_reg <= (cnt_reg + 8'h01) >= need;
                end
            end
        end
    endgenerate

    // [RQ3] kept sources stay stable, so requests see no delay
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            src_enable <= 4'h1;
        end else begin
            src_enable <= src_want;
        end
    end

    // ----
    // main clock source switch
    // ----
    // the fast oscillator is main out of reset, so its enable starts high
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sw_reg     <= MCSP_SW_IDLE;
            sel_reg    <= `MCSP_SEL_RST;
            target_reg <= MCSP_SRC_FAST;
            main_src   <= MCSP_SRC_FAST;
        end else begin
            unique case (sw_reg)
                MCSP_SW_IDLE: begin
                    // [RQ12] [RQ23] guarded select
                    if (wr_sel && reg_wdata[1:0] != main_src) begin
                        sel_reg    <= reg_wdata[1:0];
                        target_reg <= mcsp_src_e'(reg_wdata[1:0]);
                        sw_reg     <= MCSP_SW_WAIT;
                    end
                end
                MCSP_SW_WAIT: begin
                    // [RQ8] selection frozen while waiting
                    // [RQ7] switch on stable edges
                    if (stable[target_reg]) begin
                        main_src <= target_reg;
                        sw_reg   <= MCSP_SW_DONE;
                    end
                end
                MCSP_SW_DONE: sw_reg <= MCSP_SW_IDLE;
            endcase
        end
    end

    // ----
    // prescaler
    // ----
    // [RQ11] [RQ24] [RQ25] divided enable
    mcsp_prescaler u_pre (
        .clock           (clock),
        .rst_n           (rst_n),
        .prescale_enable (pen_reg),
        .division_field  (division_field_reg),
        .per_clock_en    (per_clock_en)
    );

    // ----
    // read port
    // ----
    always_comb begin
        rd_value = 8'h00;
        unique case (reg_addr)
            `MCSP_OFS_SEL:  rd_value = {6'h00, sel_reg};
            `MCSP_OFS_PRE:  rd_value = {3'h0, division_field_reg, pen_reg};
            `MCSP_OFS_LOCK: rd_value = {7'h00, lock_en_reg};
            // [RQ9] [RQ10] status flags
            `MCSP_OFS_STAT: rd_value = {stable, 3'h0,
                                        sw_reg != MCSP_SW_IDLE};
            `MCSP_OFS_FAST: rd_value = {6'h00, rsb_reg[0], 1'b0};
            `MCSP_OFS_CALA: rd_value = {2'h0, center_freq_cal};
            `MCSP_OFS_CALB: rd_value = {osc_cal_lock_fuse, 3'h0,
                                        temp_slope_cal};
            `MCSP_OFS_SLOW: rd_value = {6'h00, rsb_reg[1], 1'b0};
            `MCSP_OFS_XTAL: rd_value = {2'h0, csut_reg, 1'b0,
                                        crystal_ext_input, rsb_reg[2],
                                        xtal_en_reg};
            default:        rd_value = 8'h00;
        endcase
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_read ? rd_value : 8'h00;
        end
    end
endmodule
`default_nettype wire

// ---- dv/mcsp_top_assertions.sv ----
// port checks of the clock select block
`timescale 1ns/1ps
`default_nettype none
module mcsp_top_assertions (
    input wire logic                  clock,
    input wire logic                  rst_n,
    input wire mcsp_pkg::mcsp_sleep_e sleep_mode,
    input wire logic                  nvm_busy,
    input wire logic [3:0]            periph_req,
    input wire logic                  freq_select_fuse,
    input wire logic                  osc_cal_lock_fuse,
    input wire logic [3:0]            src_enable,
    input wire mcsp_pkg::mcsp_src_e   main_src,
    input wire logic                  main_clock_run,
    input wire logic                  per_clock_en,
    input wire logic                  fast_osc_20m,
    input wire logic [5:0]            center_freq_cal
);
    import mcsp_pkg::*;
    logic [7:0] gap_reg;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // ----
    // cycles since the last peripheral pulse
    // ----
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            gap_reg <= 8'h00;
        end else if (per_clock_en) begin
            gap_reg <= 8'h00;
        end else begin
            gap_reg <= gap_reg + 8'h01;
        end
    end
    sequence s_div_six;
        per_clock_en ##1 (!per_clock_en) [*5] ##1 per_clock_en;
    endsequence
    // slow source unused in power down
    sequence s_slow_unused;
        (sleep_mode == MCSP_PDOWN && !periph_req[1] && main_src != MCSP_SRC_SLOW) [*2];
    endsequence
    a_reset_div_six: assert property ($rose(rst_n) |-> (!per_clock_en) [*6] ##1 s_div_six)
        else $error("reset divide not six");
    a_div_bound: assert property (gap_reg < 8'h40)
        else $error("pulse gap above 64");
    a_run_awake: assert property (sleep_mode inside {MCSP_ACTIVE, MCSP_IDLE} |=> main_clock_run)
        else $error("clock stopped awake");
    a_standby_req: assert property (sleep_mode == MCSP_STANDBY && periph_req[main_src]
        |=> main_clock_run)
        else $error("standby clock stopped");
    a_pdown_nvm: assert property (sleep_mode == MCSP_PDOWN
        |=> main_clock_run == $past(nvm_busy))
        else $error("power down run not busy");
    a_switch_enabled: assert property ($changed(main_src) |-> src_enable[main_src])
        else $error("switched to idle source");
    a_src_release: assert property (s_slow_unused |=> !src_enable[1])
        else $error("unused slow source on");
    a_fuse_freq: assert property ($rose(rst_n) |=> fast_osc_20m == $past(freq_select_fuse))
        else $error("freq fuse not loaded");
    a_cal_lock: assert property (osc_cal_lock_fuse && !$rose(rst_n)
        |=> $stable(center_freq_cal))
        else $error("cal changed under lock");
endmodule
bind mcsp_top mcsp_top_assertions u_chk (
    .clock(clock), .rst_n(rst_n), .sleep_mode(sleep_mode), .nvm_busy(nvm_busy),
    .periph_req(periph_req), .freq_select_fuse(freq_select_fuse),
    .osc_cal_lock_fuse(osc_cal_lock_fuse), .src_enable(src_enable), .main_src(main_src),
    .main_clock_run(main_clock_run), .per_clock_en(per_clock_en),
    .fast_osc_20m(fast_osc_20m), .center_freq_cal(center_freq_cal)
);
`default_nettype wire

// ---- dv/mcsp_osc_model.sv ----
// oscillator models answering source enables
`timescale 1ns/1ps
`default_nettype none
module mcsp_osc_model (
    input  wire logic       slow_start,
    input  wire logic [3:0] src_enable,
    output var  logic [3:0] osc_started,
    output var  logic [3:0] osc_edge
);
    int age [4];
    // ticks off the main clock grid so the block sees unrelated edges
    initial begin
        osc_started = 4'h0;
        osc_edge = 4'h0;
        age = '{0, 0, 0, 0};
        forever begin
            #17;
            for (int i = 0; i < 4; i++) begin
                age[i] = src_enable[i] ? age[i] + 1 : 0;
                osc_started[i] = age[i] > (slow_start ? 20 : 3);
                osc_edge[i] = osc_started[i] & ~osc_edge[i];
            end
        end
    end
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// self-checking bench of the clock select block
`timescale 1ns/1ps
`default_nettype none
`include "mcsp_map.svh"
module testbench;
    import mcsp_pkg::*;
    logic clock, rst_n, reg_write, reg_read, nvm_busy, lock_fuse, slow_start;
    logic main_clock_run, per_clock_en, fast_osc_20m, xtal_in, freq_fuse;
    logic [4:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, v;
    logic [3:0] periph_req, osc_started, osc_edge, src_enable, temp_slope_cal;
    logic [5:0] center_freq_cal;
    logic [15:0] rows [13];
    mcsp_sleep_e sleep_mode;
    mcsp_src_e main_src;
    int n_fail, n_tests, k;

    mcsp_top dut (
        .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .sleep_mode(sleep_mode), .nvm_busy(nvm_busy), .periph_req(periph_req),
        .osc_started(osc_started), .osc_edge(osc_edge), .freq_select_fuse(freq_fuse),
        .center_cal_fuse(6'h2a), .temp_cal_fuse(4'h5), .osc_cal_lock_fuse(lock_fuse),
        .src_enable(src_enable), .main_src(main_src), .main_clock_run(main_clock_run),
        .per_clock_en(per_clock_en), .fast_osc_20m(fast_osc_20m),
        .center_freq_cal(center_freq_cal), .temp_slope_cal(temp_slope_cal),
        .crystal_ext_input(xtal_in)
    );
    mcsp_osc_model osc (.slow_start(slow_start), .src_enable(src_enable),
        .osc_started(osc_started), .osc_edge(osc_edge));

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic bound(input int n);
        chk("wait", 8'(n >= 2000), 8'h00);
        if (n >= 2000) results();
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    // key opens a short write window
    task automatic gw(input logic [4:0] a, input logic [7:0] d);
        wr(`MCSP_OFS_GUARD, `MCSP_GUARD_KEY);
        wr(a, d);
    endtask
    task automatic rd(input logic [4:0] a);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        @(negedge clock);
        v = reg_rdata;
    endtask
    task automatic next_pulse(output int n);
        for (n = 1; n < 2000; n++) begin
            @(negedge clock);
            if (per_clock_en === 1'b1) break;
        end
        bound(n);
    endtask
    task automatic wait_src(input mcsp_src_e s);
        int n;
        for (n = 0; n < 2000 && main_src !== s; n++) @(negedge clock);
        bound(n);
    endtask
    task automatic sl(input mcsp_sleep_e m, input logic b, input logic [3:0] r);
        @(posedge clock);
        sleep_mode <= m;
        nvm_busy <= b;
        periph_req <= r;
        repeat (4) @(negedge clock);
    endtask
    task automatic reset_dut();
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        @(negedge clock);
    endtask

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        {n_fail, n_tests, rst_n, reg_write, reg_read, nvm_busy, lock_fuse, slow_start} = '0;
        {reg_addr, reg_wdata, periph_req} = '0;
        sleep_mode = MCSP_ACTIVE;
        freq_fuse = 1'b1;
        // {prescaler value, pulse gap}
        rows = '{16'h0102, 16'h0304, 16'h0508, 16'h0710, 16'h0920, 16'h0b40, 16'h1106,
                 16'h130a, 16'h150c, 16'h1718, 16'h1930, 16'h0001, 16'h1b02};
        reset_dut();
        rd(`MCSP_OFS_PRE);
        chk("prescaler", v, `MCSP_PRE_RST);
        repeat (2) next_pulse(k);
        chk("reset gap", k[7:0], 8'h06);
        chk("freq fuse", 8'(fast_osc_20m), 8'h01);
        chk("cal fuse", 8'(center_freq_cal), 8'h2a);
        wr(`MCSP_OFS_PRE, 8'h03);
        rd(`MCSP_OFS_PRE);
        chk("unguarded", v, `MCSP_PRE_RST);
        rd(5'h08);
        chk("unmapped", v, 8'h00);
        $display("reset test done");
        for (int i = 0; i < 13; i++) begin
            gw(`MCSP_OFS_PRE, rows[i][15:8]);
            rd(`MCSP_OFS_PRE);
            chk("prescaler", v, rows[i][15:8]);
            repeat (3) next_pulse(k);
            chk("gap", k[7:0], rows[i][7:0]);
        end
        $display("prescaler table done");
        gw(`MCSP_OFS_PRE, 8'h03);
        gw(`MCSP_OFS_CALA, 8'h15);
        repeat (2) @(posedge clock);
        wr(`MCSP_OFS_CALA, 8'h07);
        rd(`MCSP_OFS_CALA);
        chk("cal", v, 8'h15);
        lock_fuse <= 1'b1;
        gw(`MCSP_OFS_CALA, 8'h07);
        rd(`MCSP_OFS_CALB);
        chk("cal b", v, 8'h85);
        chk("cal out", 8'(center_freq_cal), 8'h15);
        lock_fuse <= 1'b0;
        gw(`MCSP_OFS_LOCK, 8'h01);
        gw(`MCSP_OFS_CALA, 8'h07);
        gw(`MCSP_OFS_LOCK, 8'h00);
        gw(`MCSP_OFS_CALB, 8'h0c);
        rd(`MCSP_OFS_CALA);
        chk("cal lock en", v, 8'h15);
        chk("temp cal", 8'(temp_slope_cal), 8'h0c);
        gw(`MCSP_OFS_PRE, `MCSP_PRE_RST);
        $display("calibration test done");
        gw(`MCSP_OFS_SLOW, 8'h02);
        repeat (60) @(negedge clock);
        chk("slow kept", 8'(src_enable[1]), 8'h01);
        rd(`MCSP_OFS_STAT);
        chk("slow ready", 8'(v[5]), 8'h01);
        sl(MCSP_PDOWN, 1'b1, 4'h0);
        chk("pd busy run", 8'(main_clock_run), 8'h01);
        chk("pd slow", 8'(src_enable[1]), 8'h00);
        sl(MCSP_PDOWN, 1'b0, 4'h0);
        chk("pd run", 8'(main_clock_run), 8'h00);
        sl(MCSP_STANDBY, 1'b0, 4'h0);
        chk("sb run", 8'(main_clock_run), 8'h00);
        sl(MCSP_STANDBY, 1'b0, 4'h1);
        chk("sb req run", 8'(main_clock_run), 8'h01);
        gw(`MCSP_OFS_FAST, 8'h02);
        sl(MCSP_STANDBY, 1'b0, 4'h0);
        chk("sb rsb run", 8'(main_clock_run), 8'h01);
        gw(`MCSP_OFS_FAST, 8'h00);
        gw(`MCSP_OFS_SLOW, 8'h00);
        sl(MCSP_IDLE, 1'b0, 4'h2);
        chk("idle run", 8'(main_clock_run), 8'h01);
        chk("slow req", 8'(src_enable[1]), 8'h01);
        sl(MCSP_ACTIVE, 1'b0, 4'h4);
        chk("slow off", 8'(src_enable[1]), 8'h00);
        chk("xtal off", 8'(src_enable[2]), 8'h00);
        gw(`MCSP_OFS_XTAL, 8'h01);
        sl(MCSP_ACTIVE, 1'b0, 4'h4);
        chk("xtal on", 8'(src_enable[2]), 8'h01);
        $display("sleep test done");
        gw(`MCSP_OFS_SEL, 8'h01);
        wait_src(MCSP_SRC_SLOW);
        gw(`MCSP_OFS_SEL, 8'h02);
        rd(`MCSP_OFS_STAT);
        chk("pending", 8'(v[0]), 8'h01);
        wait_src(MCSP_SRC_XTAL);
        gw(`MCSP_OFS_XTAL, 8'h05);
        rd(`MCSP_OFS_STAT);
        chk("xtal stat", {6'h0, v[6], v[0]}, 8'h02);
        chk("xtal input", 8'(xtal_in), 8'h01);
        slow_start <= 1'b1;
        gw(`MCSP_OFS_SEL, 8'h03);
        gw(`MCSP_OFS_SEL, 8'h01);
        wait_src(MCSP_SRC_EXT);
        rd(`MCSP_OFS_STAT);
        chk("ext stat", {6'h0, v[7], v[0]}, 8'h02);
        chk("refused", 8'(main_src), 8'h03);
        $display("switch test done");
        freq_fuse <= 1'b0;
        reset_dut();
        chk("reset src", 8'(main_src), 8'h00);
        rd(`MCSP_OFS_PRE);
        chk("reset pre", v, `MCSP_PRE_RST);
        chk("freq fuse 0", 8'(fast_osc_20m), 8'h00);
        $display("second reset test done");
        results();
    end
endmodule
`default_nettype wire
